// [hw/vic_pkg.sv]
/*
 * Shared constants and carrier types for the vectored interrupt controller:
 * register offsets, field positions, reset values, vector table, source
 * order and the service-level state encoding.
 * Assumes a single 20 MHz clock domain and an 8-bit register port.
 */
package vic_pkg;

   // number of maskable sources, in priority order 0..17
   localparam int NSRC = 18;
   localparam int SRCW = 5;

   // register offsets on the 8-bit special register port
   localparam logic [7:0] ADDR_PIN_CFG = 8'hE4;
   localparam logic [7:0] ADDR_PAGE_CTRL = 8'h84;
   localparam logic [7:0] ADDR_PAGE_CUR = 8'hA7;
   localparam logic [7:0] ADDR_PAGE_NEXT = 8'h85;
   localparam logic [7:0] ADDR_PAGE_LAST = 8'h86;

   // reset values
   localparam logic [7:0] PIN_CFG_RST = 8'h00;
   localparam logic [7:0] PAGE_RST = 8'h00;
   localparam logic [7:0] PAGE_CTRL_RST = 8'h01;
   localparam logic [7:0] RESET_VEC = 8'h00;

   // external_interrupt_pin_config fields
   localparam int IN0_SEL_LSB = 0;
   localparam int IN0_POL_BIT = 3;
   localparam int IN1_SEL_LSB = 4;
   localparam int IN1_POL_BIT = 7;
   localparam int SEL_W = 3;

   // page_control_register field
   localparam int AUTO_EN_BIT = 0;

   // source indices that the logic refers to by name
   localparam logic [SRCW-1:0] SRC_EXT0 = 5'h00;
   localparam logic [SRCW-1:0] SRC_TMR0 = 5'h01;
   localparam logic [SRCW-1:0] SRC_EXT1 = 5'h02;
   localparam logic [SRCW-1:0] SRC_TMR1 = 5'h03;
   localparam logic [SRCW-1:0] SRC_CAN = 5'h10;

   // vector address per priority order
   localparam logic [7:0] VEC_TABLE [NSRC] = '{
      8'h03, 8'h0B, 8'h13, 8'h1B, 8'h23, 8'h2B, 8'h33, 8'h3B, 8'h43,
      8'h4B, 8'h53, 8'h5B, 8'h63, 8'h6B, 8'h73, 8'h7B, 8'h83, 8'h8B};

   // flags owned by other peripherals; software clears them there
   typedef struct packed {
      logic uart_receive_flag;
      logic uart_transmit_flag;
      logic timer2_high_overflow;
      logic timer2_low_overflow;
      logic spi_transfer_done;
      logic spi_write_collision;
      logic spi_mode_fault;
      logic spi_receive_overrun;
      logic smbus_flag;
      logic adc_window_flag;
      logic adc_done_flag;
      logic pca_overflow;
      logic [5:0] pca_capture_flags;
      logic pca_pwm_overflow;
      logic cmp0_rise;
      logic cmp0_fall;
      logic cmp1_rise;
      logic cmp1_fall;
      logic timer3_high_overflow;
      logic timer3_low_overflow;
      logic lin_pending_flag;
      logic reg_dropout;
      logic port_match;
   } vic_level_flags_t;

   // events that set the timer 0, timer 1 and can hardware-cleared flags held here
   typedef struct packed {
      logic can_event;
      logic tmr1_overflow;
      logic tmr0_overflow;
   } vic_hw_events_t;

   // hardware-cleared pending flags, bit 0 last
   typedef struct packed {
      logic can_pending_flag;
      logic tmr1_flag;
      logic ext1_flag;
      logic tmr0_flag;
      logic ext0_flag;
   } vic_hw_flags_t;

   // service level, gray coded along idle-low-high paths
   typedef enum logic [1:0] {
      SVC_IDLE = 2'b00,
      SVC_LOW = 2'b01,
      SVC_LOW_HIGH = 2'b11,
      SVC_HIGH = 2'b10
   } vic_svc_t;

endpackage : vic_pkg

// [hw/vic_page_stack.sv]
/*
 * Three-byte register-page stack with its control register.
 * Assumes push and pop are single-cycle strobes from the controller and
 * that writes arrive as one-cycle strobes already decoded by address.
 */
module vic_page_stack (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // stack events
   input wire logic push,
   input wire logic pop,
   input wire logic [7:0] push_page,
   // register writes
   input wire logic wr_cur,
   input wire logic wr_next,
   input wire logic wr_last,
   input wire logic wr_ctrl,
   input wire logic [7:0] wdata,
   // stack contents
   output logic [7:0] cur_q,
   output logic [7:0] next_q,
   output logic [7:0] last_q,
   output logic auto_en_q
);

   // control bit, reset to automatic paging on
   always_ff @(posedge clk) begin
      if (rst) begin
         auto_en_q <= vic_pkg::PAGE_CTRL_RST[vic_pkg::AUTO_EN_BIT];
      end else if (wr_ctrl) begin
         auto_en_q <= wdata[vic_pkg::AUTO_EN_BIT];
      end
   end

   // stack moves only when auto paging is on; a plain write is taken
   // otherwise, so a handler can retarget its return page
   always_ff @(posedge clk) begin
      if (rst) begin
         cur_q <= vic_pkg::PAGE_RST;
         next_q <= vic_pkg::PAGE_RST;
         last_q <= vic_pkg::PAGE_RST;
      // (R22) gate stack moves
      end else if (auto_en_q && push) begin
         // (R20) push on service
         cur_q <= push_page;
         next_q <= cur_q;
         last_q <= next_q;
      end else if (auto_en_q && pop) begin
         // (R20) pop on exit
         cur_q <= next_q;
         next_q <= last_q;
      end else begin
         // (R21) direct stack access
         if (wr_cur) begin
            cur_q <= wdata;
         end
         if (wr_next) begin
            next_q <= wdata;
         end
         if (wr_last) begin
            last_q <= wdata;
         end
      end
   end

endmodule : vic_page_stack

// [hw/vic_controller.sv]
/*
 * Vectored interrupt controller top: external pin interrupts, pending
 * flags, priority selection, vector output, service levels and the
 * register-page stack.
 * Assumes all inputs are synchronous to clk, enable and priority bits come
 * from the core's own enable/priority registers, and the core pulses
 * int_ack when it vectors and int_reti when it returns.
 */
// Notes on behaviour
// (R1) external 0: vector 0x0003, order 0, flag cleared when vectored
// (R2) external 1: vector 0x0013, order 2, flag cleared when vectored
// (R3) timer 0 at 0x000B order 1, timer 1 at 0x001B order 3, auto-cleared
// (R4) uart: 0x0023 order 4, receive or transmit flag, software clears
// (R5) timer 2: 0x002B order 5, high or low overflow, software clears
// (R6) spi: 0x0033 order 6, any of four flags, software clears
// (R7) smbus: 0x003B order 7, software clears its flag
// (R8) adc window 0x0043 order 8, conversion 0x004B order 9, no auto clear
// (R9) pca: 0x0053 order 10, overflow, capture or pwm flag, no auto clear
// (R10) comparators 0x005B order 11, 0x0063 order 12, edge flags
// (R11) timer 3: 0x006B order 13, high or low overflow, no auto clear
// (R12) lin: 0x0073 order 14, its flag is not cleared here
// (R13) regulator dropout: 0x007B order 15, no pending flag
// (R14) can: 0x0083 order 16, flag cleared when vectored
// (R15) port match: 0x008B lowest order 17, no pending flag
// (R16) reset vector 0x0000 comes first, cannot be masked
// (R17) polarity bits 7 and 3: 0 active low, 1 active high
// (R18) three-bit pin select picks port 1 pin 0 through 7
// (R19) pins are only observed, never driven
// (R20) page stack pushes on service and pops on return only
// (R21) all three stack bytes readable and writable by software
// (R22) clearing the auto page enable stops switching and stack moves
// (R23) high preempts low; same level, lower order number wins
module vic_controller #(
   parameter logic [7:0] SRC_PAGE [vic_pkg::NSRC] = '{default: 8'h00}
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // special register port
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata_q,
   // port 1 input levels
   input wire logic [7:0] port1_pins,
   // peripheral flags and events
   input wire vic_pkg::vic_level_flags_t level_flags,
   input wire vic_pkg::vic_hw_events_t hw_events,
   input wire vic_pkg::vic_hw_flags_t hw_flag_clr,
   output vic_pkg::vic_hw_flags_t hw_flags_q,
   // enable and priority bits, one per source in order
   input wire logic [vic_pkg::NSRC-1:0] irq_enable,
   input wire logic [vic_pkg::NSRC-1:0] irq_priority,
   // core handshake
   input wire logic int_ack,
   input wire logic int_reti,
   output logic int_req_q,
   output logic [7:0] int_vector_q,
   output logic [vic_pkg::SRCW-1:0] int_src_q,
   output logic int_high_q,
   // register-page stack
   output logic [7:0] page_cur_q,
   output logic [7:0] page_next_q,
   output logic [7:0] page_last_q,
   output logic page_auto_en_q
);

   logic [7:0] pin_cfg_q;
   logic ext0_prev_q;
   logic ext1_prev_q;
   logic ext0_level;
   logic ext1_level;
   logic [4:0] hw_set;
   logic [4:0] hw_vec_clr;
   logic [4:0] hw_q;
   logic [vic_pkg::NSRC-1:0] pend;
   logic [vic_pkg::NSRC-1:0] req;
   logic [vic_pkg::NSRC-1:0] allowed;
   logic hi_any;
   logic pick_valid;
   logic pick_high;
   logic [vic_pkg::SRCW-1:0] pick_src;
   logic taken;
   vic_pkg::vic_svc_t svc_q;
   vic_pkg::vic_level_flags_t lf;

   assign lf = level_flags;

   // pin interrupt configuration register
   always_ff @(posedge clk) begin
      if (rst) begin
         pin_cfg_q <= vic_pkg::PIN_CFG_RST;
      end else if (sfr_wr && sfr_addr == vic_pkg::ADDR_PIN_CFG) begin
         pin_cfg_q <= sfr_wdata;
      end
   end

   // (R18) pin selection
   // (R19) read-only pin tap
   always_comb begin
      ext0_level = port1_pins[pin_cfg_q[vic_pkg::IN0_SEL_LSB +:
         vic_pkg::SEL_W]];
      ext1_level = port1_pins[pin_cfg_q[vic_pkg::IN1_SEL_LSB +:
         vic_pkg::SEL_W]];
      // (R17) polarity correction
      if (!pin_cfg_q[vic_pkg::IN0_POL_BIT]) begin
         ext0_level = ~ext0_level;
      end
      if (!pin_cfg_q[vic_pkg::IN1_POL_BIT]) begin
         ext1_level = ~ext1_level;
      end
   end

   // previous active level, so a flag is set on becoming active; it tracks
   // through reset so a pin already active at release gives no false edge
   always_ff @(posedge clk) begin
      ext0_prev_q <= ext0_level;
      ext1_prev_q <= ext1_level;
   end

   // set events for the hardware-cleared flags
   assign hw_set[0] = ext0_level && !ext0_prev_q;
   assign hw_set[1] = hw_events.tmr0_overflow;
   assign hw_set[2] = ext1_level && !ext1_prev_q;
   assign hw_set[3] = hw_events.tmr1_overflow;
   assign hw_set[4] = hw_events.can_event;

   // vectoring clears the flag of the source taken
   assign taken = int_ack && int_req_q;
   // (R1) clear on vectoring
   assign hw_vec_clr[0] = taken && int_src_q == vic_pkg::SRC_EXT0;
   // (R3) clear on vectoring
   assign hw_vec_clr[1] = taken && int_src_q == vic_pkg::SRC_TMR0;
   // (R2) clear on vectoring
   assign hw_vec_clr[2] = taken && int_src_q == vic_pkg::SRC_EXT1;
   assign hw_vec_clr[3] = taken && int_src_q == vic_pkg::SRC_TMR1;
   // (R14) clear on vectoring
   assign hw_vec_clr[4] = taken && int_src_q == vic_pkg::SRC_CAN;

   // held flags; a set in the clearing cycle wins so no event is lost
   for (genvar k = 0; k < 5; k++) begin : g_hw_flag
      always_ff @(posedge clk) begin
         if (rst) begin
            hw_q[k] <= 1'b0;
         end else begin
            hw_q[k] <= hw_set[k] |
               (hw_q[k] & ~(hw_vec_clr[k] | hw_flag_clr[k]));
         end
      end
   end
   assign hw_flags_q = vic_pkg::vic_hw_flags_t'(hw_q);

   // pending per source; peripheral-owned flags pass straight through
   always_comb begin
      // (R1) external 0 order 0
      pend[0] = hw_q[0];
      // (R3) timer 0 order 1
      pend[1] = hw_q[1];
      // (R2) external 1 order 2
      pend[2] = hw_q[2];
      pend[3] = hw_q[3];
      // (R4) uart either flag
      pend[4] = lf.uart_receive_flag | lf.uart_transmit_flag;
      // (R5) timer 2 either byte
      pend[5] = lf.timer2_high_overflow | lf.timer2_low_overflow;
      // (R6) spi any flag
      pend[6] = lf.spi_transfer_done | lf.spi_write_collision |
         lf.spi_mode_fault | lf.spi_receive_overrun;
      // (R7) smbus order 7
      pend[7] = lf.smbus_flag;
      // (R8) adc two sources
      pend[8] = lf.adc_window_flag;
      pend[9] = lf.adc_done_flag;
      // (R9) pca any flag
      pend[10] = lf.pca_overflow | (|lf.pca_capture_flags) |
         lf.pca_pwm_overflow;
      // (R10) comparator edge flags
      pend[11] = lf.cmp0_rise | lf.cmp0_fall;
      pend[12] = lf.cmp1_rise | lf.cmp1_fall;
      // (R11) timer 3 either byte
      pend[13] = lf.timer3_high_overflow | lf.timer3_low_overflow;
      // (R12) lin status flag
      pend[14] = lf.lin_pending_flag;
      // (R13) dropout, no flag
      pend[15] = lf.reg_dropout;
      // (R14) can order 16
      pend[16] = hw_q[4];
      // (R15) port match lowest
      pend[17] = lf.port_match;
   end

   // (R16) every other source maskable
   assign req = pend & irq_enable;
   assign hi_any = |(req & irq_priority);

   // (R23) level admission
   always_comb begin
      case (svc_q)
         vic_pkg::SVC_IDLE: allowed = hi_any ? (req & irq_priority) : req;
         vic_pkg::SVC_LOW: allowed = req & irq_priority;
         default: allowed = '0;
      endcase
   end

   // (R23) lowest order first; scanning downward leaves the lowest index
   always_comb begin
      pick_valid = 1'b0;
      pick_src = '0;
      for (int i = vic_pkg::NSRC - 1; i >= 0; i--) begin
         if (allowed[i]) begin
            pick_valid = 1'b1;
            pick_src = vic_pkg::SRCW'(i);
         end
      end
      pick_high = irq_priority[pick_src];
   end

   // request and vector to the core; dropped for the cycle after an ack
   // so the cleared flag and new level are seen before the next pick
   always_ff @(posedge clk) begin
      if (rst) begin
         int_req_q <= 1'b0;
         // (R16) reset vector first
         int_vector_q <= vic_pkg::RESET_VEC;
         int_src_q <= '0;
         int_high_q <= 1'b0;
      end else begin
         int_req_q <= pick_valid && !taken;
         int_src_q <= pick_src;
         int_high_q <= pick_high;
         if (pick_valid) begin
            int_vector_q <= vic_pkg::VEC_TABLE[pick_src];
         end
      end
   end

   // service level tracking; a low handler may be preempted once
   always_ff @(posedge clk) begin
      if (rst) begin
         svc_q <= vic_pkg::SVC_IDLE;
      end else if (taken) begin
         case (svc_q)
            vic_pkg::SVC_IDLE: begin
               svc_q <= int_high_q ? vic_pkg::SVC_HIGH : vic_pkg::SVC_LOW;
            end
            // (R23) high preempts low
            vic_pkg::SVC_LOW: svc_q <= vic_pkg::SVC_LOW_HIGH;
            default: svc_q <= svc_q;
         endcase
      end else if (int_reti) begin
         case (svc_q)
            vic_pkg::SVC_LOW_HIGH: svc_q <= vic_pkg::SVC_LOW;
            default: svc_q <= vic_pkg::SVC_IDLE;
         endcase
      end
   end

   // (R20) push on service, pop on return
   vic_page_stack u_page_stack (
      .clk(clk),
      .rst(rst),
      .push(taken),
      .pop(int_reti && !taken),
      .push_page(SRC_PAGE[int_src_q]),
      .wr_cur(sfr_wr && sfr_addr == vic_pkg::ADDR_PAGE_CUR),
      .wr_next(sfr_wr && sfr_addr == vic_pkg::ADDR_PAGE_NEXT),
      .wr_last(sfr_wr && sfr_addr == vic_pkg::ADDR_PAGE_LAST),
      .wr_ctrl(sfr_wr && sfr_addr == vic_pkg::ADDR_PAGE_CTRL),
      .wdata(sfr_wdata),
      .cur_q(page_cur_q),
      .next_q(page_next_q),
      .last_q(page_last_q),
      .auto_en_q(page_auto_en_q)
   );

   // (R21) registered read-back
   always_ff @(posedge clk) begin
      if (rst) begin
         sfr_rdata_q <= 8'h00;
      end else if (sfr_addr == vic_pkg::ADDR_PIN_CFG) begin
         sfr_rdata_q <= pin_cfg_q;
      end else if (sfr_addr == vic_pkg::ADDR_PAGE_CUR) begin
         sfr_rdata_q <= page_cur_q;
      end else if (sfr_addr == vic_pkg::ADDR_PAGE_NEXT) begin
         sfr_rdata_q <= page_next_q;
      end else if (sfr_addr == vic_pkg::ADDR_PAGE_LAST) begin
         sfr_rdata_q <= page_last_q;
      end else if (sfr_addr == vic_pkg::ADDR_PAGE_CTRL) begin
         sfr_rdata_q <= {7'h00, page_auto_en_q};
      end else begin
         sfr_rdata_q <= 8'h00;
      end
   end

   // checks on the outputs against their causes
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   vector_table_a: assert property ( // (R15)
      int_req_q |-> int_vector_q == vic_pkg::VEC_TABLE[int_src_q])
      else $error("vector does not match source order");

   ext0_clear_a: assert property ( // (R1)
      taken && int_src_q == vic_pkg::SRC_EXT0 && !hw_set[0]
      |=> !hw_flags_q.ext0_flag)
      else $error("external 0 flag not cleared on vectoring");

   ext_edge_a: assert property ( // (R17)
      $rose(ext1_level) |=> hw_flags_q.ext1_flag)
      else $error("external 1 active edge did not set flag");

   high_blocks_a: assert property ( // (R23)
      (svc_q == vic_pkg::SVC_HIGH || svc_q == vic_pkg::SVC_LOW_HIGH)
      ##1 (svc_q == vic_pkg::SVC_HIGH || svc_q == vic_pkg::SVC_LOW_HIGH)
      |-> !int_req_q)
      else $error("request raised inside a high handler");

   preempt_a: assert property ( // (R23)
      svc_q == vic_pkg::SVC_LOW && hi_any && !taken && !int_reti
      |=> int_req_q && int_high_q)
      else $error("high request did not preempt low handler");

   push_move_a: assert property ( // (R20)
      taken && page_auto_en_q
      |=> page_next_q == $past(page_cur_q) &&
          page_last_q == $past(page_next_q))
      else $error("page stack push wrong");

   pop_move_a: assert property ( // (R20)
      int_reti && !taken && page_auto_en_q
      |=> page_cur_q == $past(page_next_q))
      else $error("page stack pop wrong");

   no_auto_a: assert property ( // (R22)
      !page_auto_en_q && (taken || int_reti) && !sfr_wr
      |=> $stable(page_cur_q) && $stable(page_next_q))
      else $error("stack moved with auto paging off");

   reset_vec_a: assert property ( // (R16)
      $fell(rst) |-> int_vector_q == vic_pkg::RESET_VEC && !int_req_q)
      else $error("reset vector not presented after reset");

   cfg_write_a: assert property ( // (R18)
      sfr_wr && sfr_addr == vic_pkg::ADDR_PIN_CFG
      |=> ##1 $past(sfr_addr) != vic_pkg::ADDR_PIN_CFG ||
          sfr_rdata_q == $past(sfr_wdata, 2) || $past(sfr_wr))
      else $error("pin configuration read-back wrong");

   low_taken_c: cover property (
      taken && !int_high_q ##[1:20] taken && int_high_q);
   nested_ret_c: cover property (
      svc_q == vic_pkg::SVC_LOW_HIGH ##[1:20] svc_q == vic_pkg::SVC_LOW);
   ext0_taken_c: cover property (
      taken && int_src_q == vic_pkg::SRC_EXT0);
   high_only_c: cover property (
      svc_q == vic_pkg::SVC_HIGH ##1 svc_q == vic_pkg::SVC_HIGH);

endmodule : vic_controller

// [tb/vic_core_model.sv]
/*
 * Stand-in for the processor core: takes a presented interrupt after a
 * chosen wait, runs each handler for a chosen length, then returns.
 * Assumes the controller's clock and reset; nesting depth is unbounded.
 */
module vic_core_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // controller handshake
   input wire logic int_req_q,
   input wire logic [7:0] int_vector_q,
   input wire logic [4:0] int_src_q,
   output logic int_ack,
   output logic int_reti,
   // bench control and report
   input var int ack_wait,
   input var int hold,
   output logic [7:0] seen_vec,
   output logic [4:0] seen_src,
   output int acks,
   output int depth
);
   timeunit 1ns;
   timeprecision 1ns;

   int wait_n = 0;
   int run_n = 0;
   logic ack_d;
   logic reti_d;

   // quiet handshake before the first edge
   initial begin
      int_ack = 1'b0;
      int_reti = 1'b0;
      acks = 0;
      depth = 0;
   end

   // never an ack and a return in one cycle, so the pop is never masked
   // each strobe is assigned once per step, after the decision is made
   always @(posedge clk) begin
      #1;
      ack_d = 1'b0;
      reti_d = 1'b0;
      if (rst) begin
         depth = 0;
         wait_n = 0;
      end else if (int_req_q && wait_n >= ack_wait) begin
         ack_d = 1'b1;
         seen_vec = int_vector_q;
         seen_src = int_src_q;
         acks++;
         depth++;
         wait_n = 0;
         run_n = 0;
      end else begin
         wait_n = int_req_q ? wait_n + 1 : 0;
         run_n = depth > 0 ? run_n + 1 : 0;
         if (depth > 0 && run_n >= hold) begin
            reti_d = 1'b1;
            depth--;
            run_n = 0;
         end
      end
      int_ack = ack_d;
      int_reti = reti_d;
   end

endmodule : vic_core_model

// [tb/test_vic_controller.sv]
/*
 * Self-checking bench for the vectored interrupt controller: registers,
 * pin interrupts, vectors, priority, nesting and the page stack.
 * Assumes the core stand-in answers requests; seed fixed at 92.
 */
module test_vic_controller;
   timeunit 1ns;
   timeprecision 1ns;

   // page loaded on entry, distinct per source
   localparam logic [7:0] PAGES [vic_pkg::NSRC] = '{
      8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47, 8'h48,
      8'h49, 8'h4A, 8'h4B, 8'h4C, 8'h4D, 8'h4E, 8'h4F, 8'h50, 8'h51};
   localparam logic [7:0] ADDRS [6] = '{
      8'hE4, 8'h84, 8'hA7, 8'h85, 8'h86, 8'h3C};
   localparam logic [7:0] RSTV [6] = '{
      8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};

   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] sfr_addr = 8'h00;
   logic sfr_wr = 1'b0;
   logic [7:0] sfr_wdata = 8'h00;
   logic [7:0] port1_pins = 8'h00;
   vic_pkg::vic_level_flags_t level_flags = '0;
   vic_pkg::vic_hw_events_t hw_events = '0;
   vic_pkg::vic_hw_flags_t hw_flag_clr = '0;
   vic_pkg::vic_hw_flags_t hw_flags_q;
   vic_pkg::vic_hw_flags_t exp_hw;
   logic [vic_pkg::NSRC-1:0] irq_enable = '0;
   logic [vic_pkg::NSRC-1:0] irq_priority = '0;
   logic int_ack, int_reti, int_req_q, int_high_q, page_auto_en_q;
   logic [7:0] sfr_rdata_q, int_vector_q, seen_vec;
   logic [7:0] page_cur_q, page_next_q, page_last_q;
   logic [vic_pkg::SRCW-1:0] int_src_q, seen_src;
   logic [7:0] v, prev, prevn, rd_v;
   logic [2:0] sel;
   logic pol, ch;
   int acks, depth, acks0;
   int ack_wait = 0;
   int hold = 6;
   int num_errors = 0;
   int check_count = 0;
   int seed = 92;

   // 20 MHz system clock
   always #25 clk = ~clk;

   vic_controller #(.SRC_PAGE(PAGES)) vic_controller_i (
      .clk, .rst, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rdata_q,
      .port1_pins, .level_flags, .hw_events, .hw_flag_clr, .hw_flags_q,
      .irq_enable, .irq_priority, .int_ack, .int_reti, .int_req_q,
      .int_vector_q, .int_src_q, .int_high_q, .page_cur_q, .page_next_q,
      .page_last_q, .page_auto_en_q);

   vic_core_model vic_core_model_i (
      .clk, .rst, .int_req_q, .int_vector_q, .int_src_q, .int_ack,
      .int_reti, .ack_wait, .hold, .seen_vec, .seen_src, .acks, .depth);

   // one counted comparison
   task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // inputs always move one step after the rising edge
   task automatic tick(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   // an idle edge after each write, so back-to-back writes never lower
   // and raise the strobe in one step
   task automatic wr(logic [7:0] a, logic [7:0] d);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      tick(1);
      sfr_wr = 1'b0;
      tick(1);
   endtask : wr

   task automatic rd(logic [7:0] a);
      sfr_addr = a;
      tick(1);
      rd_v = sfr_rdata_q;
   endtask : rd

   task automatic close_out();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : close_out

   // returns just after the edge that took the ack; core wait is random
   task automatic wait_ack();
      int n0;
      n0 = acks;
      ack_wait = $random(seed) & 3;
      repeat (100) begin
         @(posedge clk);
         if (acks != n0) break;
      end
      #1;
      if (acks == n0) begin
         num_errors++;
         $display("FAIL core ack expected 1 seen 0");
         close_out();
      end
   endtask : wait_ack

   // returns just after the edge that took the last return
   task automatic wait_idle();
      repeat (200) begin
         @(posedge clk);
         if (depth == 0) break;
      end
      #1;
      if (depth != 0) begin
         num_errors++;
         $display("FAIL handler return expected 0 seen %0d", depth);
         close_out();
      end
   endtask : wait_idle

   initial begin
      tick(6);
      rst = 1'b0;
      check("request", 8'(int_req_q), 8'h00);
      check("vector", int_vector_q, 8'h00);
      for (int k = 0; k < 6; k++) begin
         rd(ADDRS[k]);
         check("reset read", rd_v, RSTV[k]);
      end
      v = 8'($random(seed));
      wr(8'hE4, v);
      rd(8'hE4);
      check("pin config", rd_v, v);
      wr(8'h3C, 8'hFF);
      rd(8'h3C);
      check("unmapped", rd_v, 8'h00);
      // every polarity and pin code, others toggling at random
      for (int k = 0; k < 32; k++) begin
         sel = k[2:0];
         pol = k[3];
         ch = k[4];
         wr(8'hE4, ch ? {pol, sel, 4'h0} : {4'h0, pol, sel});
         v = 8'($random(seed));
         v[sel] = ~pol;
         port1_pins = v;
         tick(3);
         hw_flag_clr = 5'h05;
         tick(1);
         hw_flag_clr = '0;
         v = 8'($random(seed));
         v[sel] = ~pol;
         port1_pins = v;
         tick(3);
         check("other pin", 8'(hw_flags_q[ch ? 2 : 0]), 8'h00);
         port1_pins[sel] = pol;
         tick(3);
         check("chosen pin", 8'(hw_flags_q[ch ? 2 : 0]), 8'h01);
      end
      // every source pending at once
      wr(8'hE4, 8'h98);
      port1_pins = 8'h00;
      level_flags = '1;
      tick(2);
      hw_flag_clr = '1;
      tick(1);
      hw_flag_clr = '0;
      hw_events = '1;
      port1_pins = 8'h03;
      tick(1);
      hw_events = '0;
      tick(2);
      exp_hw = '1;
      check("held flags", 8'(hw_flags_q), 8'(exp_hw));
      // vectors one source at a time, stack edited in handler
      for (int i = 0; i < vic_pkg::NSRC; i++) begin
         prev = page_cur_q;
         prevn = page_next_q;
         irq_enable = 18'(1) << i;
         wait_ack();
         check("vector", seen_vec, 8'h03 + 8'(8 * i));
         check("source", 8'(seen_src), 8'(i));
         check("page current", page_cur_q, PAGES[i]);
         check("page next", page_next_q, prev);
         check("page last", page_last_q, prevn);
         if (i < 4) exp_hw[i] = 1'b0;
         if (i == 16) exp_hw[4] = 1'b0;
         check("held flags", 8'(hw_flags_q), 8'(exp_hw));
         v = 8'($random(seed));
         wr(8'h85, v);
         irq_enable = '0;
         wait_idle();
         check("page return", page_cur_q, v);
      end
      // no push or pop with auto paging off
      wr(8'h84, 8'h00);
      prev = page_cur_q;
      wr(8'h85, ~prev);
      irq_enable = 18'(1) << 4;
      wait_ack();
      check("frozen push", page_cur_q, prev);
      irq_enable = '0;
      wait_idle();
      check("frozen pop", page_cur_q, prev);
      wr(8'h84, 8'h01);
      // low handler preempted; lower order wins among high
      hold = 40;
      irq_enable = 18'(1) << 4;
      wait_ack();
      check("low first", 8'(seen_src), 8'h04);
      check("low level", 8'(int_high_q), 8'h00);
      irq_priority = 18'h00280;
      irq_enable = '1;
      wait_ack();
      check("preempt", 8'(seen_src), 8'h07);
      check("nest depth", 8'(depth), 8'h02);
      check("preempt level", 8'(int_high_q), 8'h01);
      irq_enable = '0;
      wait_idle();
      // a high handler entered from idle admits nothing more
      acks0 = acks;
      irq_enable = 18'(1) << 9;
      wait_ack();
      check("high first", 8'(seen_src), 8'h09);
      check("high level", 8'(int_high_q), 8'h01);
      irq_enable = '1;
      wait_idle();
      check("high blocks", 8'(acks - acks0), 8'h01);
      irq_enable = '0;
      tick(2);
      close_out();
   end

endmodule : test_vic_controller
